/* File: lbr_defs.vh */
// constants for the long branch condition unit
`ifndef LBR_DEFS_VH
`define LBR_DEFS_VH

// ----------------------------------------
// opcode bytes
// ----------------------------------------
`define LBR_PREBYTE                   8'h18
`define LBR_OP_ALWAYS                 8'h20
`define LBR_OP_NEVER                  8'h21
`define LBR_OP_HIGHER                 8'h22
`define LBR_OP_LOWER_OR_SAME          8'h23
`define LBR_OP_CARRY_CLEAR            8'h24
`define LBR_OP_CARRY_SET              8'h25
`define LBR_OP_NOT_EQUAL              8'h26
`define LBR_OP_EQUAL                  8'h27
`define LBR_OP_OVERFLOW_CLEAR         8'h28
`define LBR_OP_OVERFLOW_SET           8'h29
`define LBR_OP_POSITIVE               8'h2a
`define LBR_OP_NEGATIVE               8'h2b
`define LBR_OP_SIGNED_GREATER_EQUAL   8'h2c
`define LBR_OP_SIGNED_LESS            8'h2d
`define LBR_OP_SIGNED_GREATER         8'h2e
`define LBR_OP_SIGNED_LESS_EQUAL      8'h2f

// ----------------------------------------
// condition code bit positions (s x h i n z v c)
// ----------------------------------------
`define CCR_N                         3
`define CCR_Z                         2
`define CCR_V                         1
`define CCR_C                         0

// ----------------------------------------
// timing and target arithmetic
// ----------------------------------------
`define LBR_PC_STEP                   16'h0004
`define LBR_TAKEN_CYCLES              3'h4
`define LBR_NOT_TAKEN_CYCLES          3'h3

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define REG_CTRL                      4'h0
`define REG_STATUS                    4'h4
`define REG_TARGET                    4'h8
`define REG_TAKEN_COUNT               4'hc
`define CTRL_RESET                    32'h0000_0001
`define AXI_OKAY                      2'b00
`define AXI_SLVERR                    2'b10

`endif

/* File: lbr_cond_eval.v */
// condition evaluator: opcode decode and flag test for long branches
`timescale 1ns/1ps
`include "lbr_defs.vh"

module lbr_cond_eval
(
   input  wire [7:0] prebyte,   // first opcode byte
   input  wire [7:0] opcode,    // second opcode byte
   input  wire [7:0] ccr,       // condition codes
   output reg        known,     // opcode is a long branch
   output reg        take       // branch condition holds
);

   wire n = ccr[`CCR_N];
   wire z = ccr[`CCR_Z];
   wire v = ccr[`CCR_V];
   wire c = ccr[`CCR_C];

   // ----------------------------------------
   // decode
   // ----------------------------------------
   // flags are only read, never written back
   always @*
   begin
      known = (prebyte == `LBR_PREBYTE);
      take  = 1'b0;
      case (opcode)
         `LBR_OP_ALWAYS                : take = 1'b1;               // [RULE16]
         `LBR_OP_NEVER                 : take = 1'b0;               // [RULE16]
         `LBR_OP_HIGHER                : take = ~(c | z);           // [RULE11] [RULE2]
         `LBR_OP_LOWER_OR_SAME         : take = c | z;              // [RULE1] [RULE2] [RULE5] [RULE6]
         `LBR_OP_CARRY_CLEAR           : take = ~c;                 // [RULE12]
         `LBR_OP_CARRY_SET             : take = c;                  // [RULE13]
         `LBR_OP_NOT_EQUAL             : take = ~z;                 // [RULE10]
         `LBR_OP_EQUAL                 : take = z;                  // [RULE10]
         `LBR_OP_OVERFLOW_CLEAR        : take = ~v;                 // [RULE15]
         `LBR_OP_OVERFLOW_SET          : take = v;                  // [RULE15]
         `LBR_OP_POSITIVE              : take = ~n;                 // [RULE14]
         `LBR_OP_NEGATIVE              : take = n;                  // [RULE14]
         `LBR_OP_SIGNED_GREATER_EQUAL  : take = ~(n ^ v);           // [RULE9]
         `LBR_OP_SIGNED_LESS           : take = n ^ v;              // [RULE9]
         `LBR_OP_SIGNED_GREATER        : take = ~(z | (n ^ v));     // [RULE8]
         `LBR_OP_SIGNED_LESS_EQUAL     : take = z | (n ^ v);        // [RULE8]
         default                       : known = 1'b0;
      endcase
      take = take & known;
   end

endmodule

/* File: lbr_target_add.v */
// target adder: old pc plus four plus signed 16-bit offset
`timescale 1ns/1ps
`include "lbr_defs.vh"

module lbr_target_add
(
   input  wire [15:0] pc,         // address of the prebyte
   input  wire [7:0]  off_hi,     // offset high byte, first after opcode
   input  wire [7:0]  off_lo,     // offset low byte
   output wire [15:0] target      // branch destination
);

   // ----------------------------------------
   // add
   // ----------------------------------------
   // 16-bit sum wraps, so a negative offset needs no sign extension
   wire [15:0] offset_16bit = {off_hi, off_lo};               // [RULE18]
   assign target = pc + `LBR_PC_STEP + offset_16bit;           // [RULE1] [RULE18]

endmodule

/* File: long_branch_condition_unit.v */
// long branch condition unit: sequencer side plus axi4-lite registers
// Function
// RULE1: lower-or-same takes on c or z; pc+4+offset
// RULE2: 18 23 lower-or-same, complement 18 22
// RULE3: taken branch spends four cycles refilling
// RULE4: untaken branch spends three cycles
// RULE5: unsigned register<=memory takes lower-or-same
// RULE6: after acc pair compare, b<=a takes
// RULE7: software avoids lower-or-same after carry-neutral ops
// RULE8: 18 2e/2f test z or (n xor v)
// RULE9: 18 2c/2d test n xor v
// RULE10: 18 27 on z, 18 26 on not z
// RULE11: 18 22 takes when c and z are both clear
// RULE12: 18 24 takes when carry clear
// RULE13: 18 25 takes when carry set
// RULE14: 18 2b on n, 18 2a on not n
// RULE15: 18 29 on v, 18 28 on not v
// RULE16: 18 20 always, 18 21 never branches
// RULE17: flags pass through unchanged
// RULE18: target wraps mod 2^16, offset high first
`timescale 1ns/1ps
`include "lbr_defs.vh"

module long_branch_condition_unit
#(
   parameter CNT_W = 32                   // width of the taken counter
)
(
   input  wire        mclk,               // cpu clock, 125 mhz
   input  wire        rstn,               // async reset, active low
   // instruction request from the queue
   input  wire        req_valid,          // a long branch is presented
   output wire        req_ready,          // unit is idle and enabled
   input  wire [7:0]  req_prebyte,        // opcode byte one
   input  wire [7:0]  req_opcode,         // opcode byte two
   input  wire [7:0]  req_off_hi,         // offset high byte
   input  wire [7:0]  req_off_lo,         // offset low byte
   input  wire [15:0] req_pc,             // pc of the prebyte
   input  wire [7:0]  req_ccr,            // condition codes
   // result to the sequencer
   output wire        res_valid,          // one-cycle result pulse
   output wire        res_known,          // opcode was a long branch
   output wire        res_taken,          // branch taken
   output wire [15:0] res_pc,             // next pc
   output wire [2:0]  res_cycles,         // cycles the instruction used
   output wire [7:0]  res_ccr,            // flags, unchanged
   // axi4-lite slave
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam ST_IDLE = 1'b0;             // waiting for a request
   localparam ST_RUN  = 1'b1;             // counting instruction cycles

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // register offset match, shared by read and write decode
   function is_reg;
      input [3:0] addr;
      input [3:0] offs;
      begin
         is_reg = (addr[3:2] == offs[3:2]);
      end
   endfunction

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   reg              state_ff;             // sequencer state
   reg              nxt_state;
   reg  [2:0]       cyc_ff;               // cycles left in this instruction
   reg  [2:0]       nxt_cyc;
   reg  [2:0]       total_ff;             // cycles charged to instruction
   reg              known_ff;             // captured decode result
   reg              taken_ff;             // captured condition result
   reg  [15:0]      pc_ff;                // captured next pc
   reg  [7:0]       ccr_ff;               // captured flags
   reg              ready_ff;             // request ready
   reg              res_valid_ff;         // result pulse
   reg              res_known_ff;
   reg              res_taken_ff;
   reg  [15:0]      res_pc_ff;
   reg  [2:0]       res_cycles_ff;
   reg  [7:0]       res_ccr_ff;
   reg              enable_ff;            // ctrl bit 0: accept requests
   reg  [CNT_W-1:0] taken_cnt_ff;         // count of taken branches
   reg  [15:0]      last_target_ff;       // target of the last taken branch

   wire             dec_known;            // decoder: long branch opcode
   wire             dec_take;             // decoder: condition holds
   wire [15:0]      add_target;           // adder: taken destination
   wire [15:0]      seq_pc;               // sequential pc, four bytes on
   wire             accept;               // request taken this cycle

   // ----------------------------------------
   // datapath instances
   // ----------------------------------------
   lbr_cond_eval u_cond
   (
      .prebyte (req_prebyte),
      .opcode  (req_opcode),
      .ccr     (req_ccr),
      .known   (dec_known),
      .take    (dec_take)
   );

   lbr_target_add u_add
   (
      .pc      (req_pc),
      .off_hi  (req_off_hi),
      .off_lo  (req_off_lo),
      .target  (add_target)
   );

   // untaken and never-branch both skip the whole four bytes
   assign seq_pc = req_pc + `LBR_PC_STEP;                        // [RULE16] [RULE4]
   assign accept = req_valid & ready_ff;

   // ----------------------------------------
   // sequencer next state
   // ----------------------------------------
   always @*
   begin
      nxt_state = state_ff;
      nxt_cyc   = cyc_ff;
      case (state_ff)
         ST_IDLE :
         begin
            if (accept)
            begin
               nxt_state = ST_RUN;
               // one cycle is the accept edge itself
               if (dec_take)
                  nxt_cyc = `LBR_TAKEN_CYCLES - 3'h1;            // [RULE3]
               else
                  nxt_cyc = `LBR_NOT_TAKEN_CYCLES - 3'h1;        // [RULE4]
            end
         end
         default :
         begin
            nxt_cyc = cyc_ff - 3'h1;
            if (cyc_ff == 3'h1)
               nxt_state = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // sequencer registers
   // ----------------------------------------
   // ready drops on accept and returns with the result, so a
   // back-to-back request cannot overlap a running instruction
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= ST_IDLE;
         cyc_ff   <= 3'h0;
         total_ff <= 3'h0;
         known_ff <= 1'b0;
         taken_ff <= 1'b0;
         pc_ff    <= 16'h0000;
         ccr_ff   <= 8'h00;
         ready_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cyc_ff   <= nxt_cyc;
         if (accept)
         begin
            known_ff <= dec_known;
            taken_ff <= dec_take;
            ccr_ff   <= req_ccr;                                 // [RULE17]
            if (dec_take)
            begin
               pc_ff    <= add_target;                           // [RULE1]
               total_ff <= `LBR_TAKEN_CYCLES;                    // [RULE3]
            end
            else
            begin
               pc_ff    <= seq_pc;                               // [RULE4]
               total_ff <= `LBR_NOT_TAKEN_CYCLES;                // [RULE4]
            end
         end
         ready_ff <= (nxt_state == ST_IDLE) & enable_ff;
      end
   end

   // ----------------------------------------
   // result outputs
   // ----------------------------------------
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         res_valid_ff  <= 1'b0;
         res_known_ff  <= 1'b0;
         res_taken_ff  <= 1'b0;
         res_pc_ff     <= 16'h0000;
         res_cycles_ff <= 3'h0;
         res_ccr_ff    <= 8'h00;
      end
      else
      begin
         res_valid_ff <= 1'b0;
         // result appears on the edge that ends the last cycle
         if ((state_ff == ST_RUN) && (cyc_ff == 3'h1))
         begin
            res_valid_ff  <= 1'b1;
            res_known_ff  <= known_ff;
            res_taken_ff  <= taken_ff;
            res_pc_ff     <= pc_ff;
            res_cycles_ff <= total_ff;
            res_ccr_ff    <= ccr_ff;                             // [RULE17]
         end
      end
   end

   assign req_ready  = ready_ff;
   assign res_valid  = res_valid_ff;
   assign res_known  = res_known_ff;
   assign res_taken  = res_taken_ff;
   assign res_pc     = res_pc_ff;
   assign res_cycles = res_cycles_ff;
   assign res_ccr    = res_ccr_ff;

   // ----------------------------------------
   // statistics registers
   // ----------------------------------------
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         taken_cnt_ff   <= {CNT_W{1'b0}};
         last_target_ff <= 16'h0000;
      end
      else if (accept && dec_take)
      begin
         taken_cnt_ff   <= taken_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
         last_target_ff <= add_target;
      end
   end

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   reg        awready_ff;                 // address slot empty
   reg        wready_ff;                  // data slot empty
   reg [3:0]  awaddr_ff;                  // held write address
   reg [31:0] wdata_ff;                   // held write data
   reg [3:0]  wstrb_ff;                   // held byte enables
   reg        bvalid_ff;
   reg [1:0]  bresp_ff;
   wire       aw_done = awready_ff & s_axi_awvalid;
   wire       w_done  = wready_ff & s_axi_wvalid;
   // both halves held, response slot free
   wire       wr_go   = ~awready_ff & ~wready_ff & ~bvalid_ff;

   // address and data may arrive in either order; each slot
   // closes once filled and reopens after the response
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         awaddr_ff  <= 4'h0;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `AXI_OKAY;
         enable_ff  <= 1'b1;
      end
      else
      begin
         if (aw_done)
         begin
            awaddr_ff  <= s_axi_awaddr;
            awready_ff <= 1'b0;
         end
         if (w_done)
         begin
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
            wready_ff <= 1'b0;
         end
         if (wr_go)
         begin
            bvalid_ff <= 1'b1;
            if (is_reg(awaddr_ff, `REG_CTRL))
            begin
               bresp_ff <= `AXI_OKAY;
               if (wstrb_ff[0])
                  enable_ff <= wdata_ff[0];
            end
            else if (is_reg(awaddr_ff, `REG_STATUS) ||
                     is_reg(awaddr_ff, `REG_TARGET) ||
                     is_reg(awaddr_ff, `REG_TAKEN_COUNT))
               bresp_ff <= `AXI_OKAY;   // read-only, write ignored
            else
               bresp_ff <= `AXI_SLVERR;
         end
         if (bvalid_ff && s_axi_bready)
         begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   reg        arready_ff;
   reg        rvalid_ff;
   reg [31:0] rdata_ff;
   reg [1:0]  rresp_ff;
   wire       ar_done = arready_ff & s_axi_arvalid;

   // one read in flight; arready drops until the data is taken
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= `AXI_OKAY;
      end
      else if (ar_done)
      begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rresp_ff   <= `AXI_OKAY;
         if (is_reg(s_axi_araddr, `REG_CTRL))
            rdata_ff <= {31'h0000_0000, enable_ff};
         else if (is_reg(s_axi_araddr, `REG_STATUS))
            rdata_ff <= {16'h0000, res_ccr_ff, 1'b0, res_cycles_ff,
                         res_known_ff, res_taken_ff, state_ff, ready_ff};
         else if (is_reg(s_axi_araddr, `REG_TARGET))
            rdata_ff <= {16'h0000, last_target_ff};
         else if (is_reg(s_axi_araddr, `REG_TAKEN_COUNT))
            rdata_ff <= taken_cnt_ff[31:0];
         else
         begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `AXI_SLVERR;
         end
      end
      else if (rvalid_ff && s_axi_rready)
      begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

endmodule

/* File: lbr_checker_sva.sv */
// port checks for the long branch condition unit
`timescale 1ns/1ps
`include "lbr_defs.vh"
module lbr_checker_sva
(
   input logic        mclk,
   input logic        rstn,
   input logic        req_valid,
   input logic        req_ready,
   input logic [7:0]  req_prebyte,
   input logic [7:0]  req_opcode,
   input logic [7:0]  req_off_hi,
   input logic [7:0]  req_off_lo,
   input logic [15:0] req_pc,
   input logic [7:0]  req_ccr,
   input logic        res_valid,
   input logic        res_taken,
   input logic [15:0] res_pc,
   input logic [2:0]  res_cycles,
   input logic [7:0]  res_ccr
);
   // --------------------
   // helpers
   // --------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire acc     = req_valid && req_ready;                  // accept edge
   wire lbr     = acc && (req_prebyte == `LBR_PREBYTE);     // long branch prebyte taken in
   wire lo_same = req_ccr[`CCR_C] | req_ccr[`CCR_Z];        // carry or zero
   // --------------------
   // properties
   // --------------------
   property p_short; acc ##3 res_valid |-> !res_taken && res_cycles == 3'h3; endproperty
   property p_long; acc ##3 !res_valid |-> ##1 (res_valid && res_taken && res_cycles == 3'h4); endproperty
   property p_busy; acc |=> (!req_ready) [*2]; endproperty
   property p_pulse; res_valid |=> !res_valid; endproperty
   property p_ccr; acc ##3 res_valid |-> res_ccr == $past(req_ccr, 3); endproperty
   property p_pc_seq; acc ##3 res_valid |-> res_pc == 16'($past(req_pc, 3) + `LBR_PC_STEP); endproperty
   property p_pc_tgt;
      acc ##4 (res_valid && res_taken) |->
         res_pc == 16'($past(req_pc, 4) + `LBR_PC_STEP + {$past(req_off_hi, 4), $past(req_off_lo, 4)});
   endproperty
   property p_never; lbr && req_opcode == `LBR_OP_NEVER |-> ##3 (res_valid && !res_taken); endproperty
   property p_always; lbr && req_opcode == `LBR_OP_ALWAYS |-> ##4 (res_valid && res_taken); endproperty
   property p_lower_same;
      lbr && req_opcode == `LBR_OP_LOWER_OR_SAME |->
         if (lo_same) ##4 (res_valid && res_taken) else ##3 (res_valid && !res_taken);
   endproperty
   property p_higher;
      lbr && req_opcode == `LBR_OP_HIGHER |->
         if (!lo_same) ##4 (res_valid && res_taken) else ##3 (res_valid && !res_taken);
   endproperty
   // --------------------
   // assertions and covers
   // --------------------
   a_short: assert property (p_short) else $error("short result wrong");
   a_long: assert property (p_long) else $error("taken result wrong");
   a_busy: assert property (p_busy) else $error("accepted while busy");
   a_pulse: assert property (p_pulse) else $error("result pulse too long");
   a_ccr: assert property (p_ccr) else $error("flags changed");
   a_pc_seq: assert property (p_pc_seq) else $error("sequential pc wrong");
   a_pc_tgt: assert property (p_pc_tgt) else $error("target pc wrong");
   a_never: assert property (p_never) else $error("never branch taken");
   a_always: assert property (p_always) else $error("always branch not taken");
   a_lower_same: assert property (p_lower_same) else $error("lower or same wrong");
   a_higher: assert property (p_higher) else $error("higher wrong");
   c_taken: cover property (acc ##4 (res_valid && res_taken));
   c_seq: cover property (acc ##3 (res_valid && !res_taken));
   c_b2b: cover property (res_valid && acc);
endmodule

/* File: queue_model.sv */
// instruction queue model that presents long branches to the unit
`timescale 1ns/1ps
module queue_model
(
   input  logic        mclk,
   input  logic        req_ready,
   output logic        req_valid,
   output logic [7:0]  req_prebyte,
   output logic [7:0]  req_opcode,
   output logic [7:0]  req_off_hi,
   output logic [7:0]  req_off_lo,
   output logic [15:0] req_pc,
   output logic [7:0]  req_ccr
);
   // idle at time zero
   initial
   begin
      req_valid = 1'b0;
      {req_prebyte, req_opcode, req_off_hi, req_off_lo, req_pc, req_ccr} = '0;
   end
   // flags come straight from the caller; software sequencing is not modelled
   // one edge first, so valid never drops and rises in one step
   task automatic send(input logic [7:0] pre, op, hi, lo, input logic [15:0] pc, input logic [7:0] ccr,
                       input int stall);
      repeat (stall + 1) @(posedge mclk);
      req_valid <= 1'b1;
      {req_prebyte, req_opcode, req_off_hi, req_off_lo, req_pc, req_ccr} <= {pre, op, hi, lo, pc, ccr};
      @(posedge mclk);
      while (req_ready !== 1'b1)
         @(posedge mclk);
      req_valid <= 1'b0;
      // released lines show the inverse, never a stale copy
      {req_prebyte, req_opcode, req_off_hi, req_off_lo, req_pc, req_ccr} <= ~{pre, op, hi, lo, pc, ccr};
   endtask
endmodule

/* File: long_branch_condition_unit_bench.sv */
// self-checking bench for the long branch condition unit
`timescale 1ns/1ps
`include "lbr_defs.vh"
module long_branch_condition_unit_bench;
   // --------------------
   // signals
   // --------------------
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        req_valid, req_ready, res_valid, res_known, res_taken;
   logic [7:0]  req_prebyte, req_opcode, req_off_hi, req_off_lo, req_ccr, res_ccr;
   logic [15:0] req_pc, res_pc, last_tgt;
   logic [2:0]  res_cycles;
   logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [35:0] eq[$], rq[$];                       // expected results, expected reads
   int          mismatches = 0, n_tests = 0, n_taken = 0;
   // --------------------
   // instances and clock
   // --------------------
   long_branch_condition_unit long_branch_condition_unit_i (.*);
   queue_model queue_model_i (.*);
   always #4 mclk = ~mclk;                           // 125 mhz
   // --------------------
   // helpers
   // --------------------
   task automatic check(input logic [35:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // one write: aw and w offered together, each dropped when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
      @(posedge mclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do
      begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, resp);
   endtask
   // one read; the monitor checks the answer against the note
   task automatic rd(input logic [3:0] a, input logic [33:0] exp);
      rq.push_back(exp);
      @(posedge mclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do
      begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask
   // reference condition per opcode, from the flag equations alone
   function automatic logic cond(input logic [7:0] op, ccr);
      logic n, z, v, c;
      {n, z, v, c} = ccr[3:0];
      case (op)
         8'h20: return 1'b1;
         8'h21: return 1'b0;
         8'h22: return !(c | z);
         8'h23: return c | z;
         8'h24: return !c;
         8'h25: return c;
         8'h26: return !z;
         8'h27: return z;
         8'h28: return !v;
         8'h29: return v;
         8'h2a: return !n;
         8'h2b: return n;
         8'h2c: return !(n ^ v);
         8'h2d: return n ^ v;
         8'h2e: return !(z | (n ^ v));
         8'h2f: return z | (n ^ v);
         default: return 1'b0; // not a long branch
      endcase
   endfunction
   // note the expected result, then send it
   task automatic issue(input logic [7:0] pre, op, input logic [15:0] off, pc, input logic [7:0] ccr,
                        input logic tk);
      logic kn;
      kn = (pre == 8'h18) && (op[7:4] == 4'h2);
      eq.push_back({kn, tk, tk ? 3'h4 : 3'h3, ccr, 16'(pc + 16'h0004 + (tk ? off : 16'h0))});
      if (tk)
      begin
         n_taken++;
         last_tgt = 16'(pc + 16'h0004 + off);
      end
      queue_model_i.send(pre, op, off[15:8], off[7:0], pc, ccr, $urandom_range(0, 3));
   endtask
   // --------------------
   // monitor: oldest note against each result
   // --------------------
   always @(posedge mclk)
   begin
      if (res_valid === 1'b1)
         check({res_known, res_taken, res_cycles, res_ccr, res_pc}, eq.size() ? eq.pop_front() : 'x);
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
         check({s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 'x);
   end
   // --------------------
   // main sequence and watchdog
   // --------------------
   initial
   begin
      logic [7:0]  ccr;
      logic [15:0] r, m;
      void'($urandom(32'h94383b42));
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      rd(4'h0, {`AXI_OKAY, 32'h1});
      rd(4'h1, {`AXI_OKAY, 32'h1});                  // low bits ignored
      wr(4'h1, 32'h0, `AXI_OKAY);
      wr(4'h0, 32'h0, `AXI_OKAY);
      repeat (2) @(posedge mclk);
      check(req_ready, 1'b0);
      wr(4'h0, 32'h1, `AXI_OKAY);
      // every opcode against every flag combination
      for (int i = 0; i < 256; i++)
      begin
         ccr = {4'($urandom), i[3:0]};
         issue(8'h18, {4'h2, i[7:4]}, 16'($urandom), 16'($urandom), ccr, cond({4'h2, i[7:4]}, ccr));
      end
      // unsigned compare r-m, or b against a
      for (int k = 0; k < 12; k++)
      begin
         r = 16'($urandom_range(0, 5));
         m = 16'($urandom_range(0, 5));
         issue(8'h18, 8'h23, 16'($urandom), 16'($urandom), {5'h0, r == m, 1'b0, r < m}, r <= m);
      end
      issue(8'h18, 8'h20, 16'h8000, 16'hffff, 8'hff, 1'b1);
      issue(8'h19, 8'h23, 16'h0010, 16'h1234, 8'h01, 1'b0);
      issue(8'h18, 8'h30, 16'h0010, 16'h1234, 8'h01, 1'b0);
      for (int t = 0; t < 50 && eq.size() > 0; t++)
         @(posedge mclk);
      check(eq.size(), 0);
      rd(4'h8, {`AXI_OKAY, 16'h0, last_tgt});
      rd(4'hc, {`AXI_OKAY, 32'(n_taken)});
      rd(4'h4, {`AXI_OKAY, 32'h0000_0131});
      end_of_test();
   end
   initial
   begin
      #100000;
      mismatches++;
      end_of_test();
   end
endmodule
bind long_branch_condition_unit lbr_checker_sva lbr_checker_sva_i (.*);
